/* hdl/sx_pkg.sv */
// Constants, types and helpers shared by the serial transceiver.
// Assumes a single 50 MHz master clock and an APB master with 32-bit data.
// Operation
// R1: Each character is 8 data bits, no parity, one stop bit.
// R2: Transmit line sits high while no character is being sent.
// R3: Start bit low, data LSB first, stop bit high.
// R4: Transmitter drives exactly ten bit periods per character.
// R5: Status bit 4 framing error, bit 3 overrun, bit 2 receive full.
// R6: Status bit 1 transmit holding full, bit 0 transmit shifter running.
// R7: On receive transfer, overrun takes the previous receive-full value.
// R8: Low data read returns character in 7:0, clears receive full.
// R9: Receive interrupt pulses when a character reaches the holding register.
// R10: Low data write takes bits 7:0; idle transmitter starts at once.
// R11: Write while busy sets transmit full and holds the character.
// R12: High data register works alike with the character in 15:8.
// R13: Divider: first divider in 15:8, second in 7:0, resets to zero.
// R14: Software keeps second divider within 6..255 and sets dividers first.
// R15: Bit rate is master clock over (first divider plus one) times second.
// R16: Holding empties and transmit interrupt fires when shifting starts.
// R17: Software writes one character per transmit interrupt, never when full.
// R18: A falling receive line while idle marks a start bit.
// R19: Data bits sampled mid-bit by fixed timer, shifted in LSB first.
// R20: Low stop bit sets framing error, then receiver returns idle.
// R21: Receive sampling tick is the first divider output.
// R22: First data sample 1.5 bits after start edge; interrupts are pulses.

package sx_pkg;

    // ----------------------------------------------------------------
    // Register map (printed offsets are word indices)
    // ----------------------------------------------------------------
    localparam logic [31:0] IDX_STATUS = 32'h0000C028;
    localparam logic [31:0] IDX_CHAR_LO = 32'h0000C029;
    localparam logic [31:0] IDX_CHAR_HI = 32'h0000C02A;
    localparam logic [31:0] IDX_DIV = 32'h0000C02B;
    localparam logic [31:0] ADDR_STATUS = IDX_STATUS << 2;
    localparam logic [31:0] ADDR_CHAR_LO = IDX_CHAR_LO << 2;
    localparam logic [31:0] ADDR_CHAR_HI = IDX_CHAR_HI << 2;
    localparam logic [31:0] ADDR_DIV = IDX_DIV << 2;

    // ----------------------------------------------------------------
    // Fields
    // ----------------------------------------------------------------
    localparam int ST_FRAME = 4;
    localparam int ST_ORUN = 3;
    localparam int ST_RXFULL = 2;
    localparam int ST_TXFULL = 1;
    localparam int ST_TXRUN = 0;
    localparam int ST_W = 5;
    localparam int CHAR_W = 8;
    localparam int CHAR_LO_LSB = 0;
    localparam int CHAR_HI_LSB = 8;
    localparam int DIV_D1_LSB = 8;
    localparam int DIV_D2_LSB = 0;
    localparam logic [15:0] DIV_RST = 16'h0000;
    localparam logic [7:0] CHAR_RST = 8'h00;

    // ----------------------------------------------------------------
    // Framing
    // ----------------------------------------------------------------
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic START_BIT = 1'b0;
    localparam logic STOP_BIT = 1'b1;
    localparam logic LINE_IDLE = 1'b1;

    typedef enum logic {TX_IDLE, TX_SHIFT} sx_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_STOP} sx_rx_state_t;

    // A limit of zero ends the bit on every tick so a bad divider cannot hang
    function automatic logic sx_bit_done(input logic [8:0] cnt, input logic [8:0] lim);
        sx_bit_done = (lim == 9'h000) ? 1'b1 : (cnt >= lim - 9'h001);
    endfunction : sx_bit_done

endpackage : sx_pkg

/* hdl/sx_prescaler.sv */
// First divider: one tick every prescale+1 master clocks.
// Assumes prescale comes from a register on the same clock.
`timescale 1ns/1ps

module sx_prescaler
(
    input logic i_sys_clk,
    input logic i_rst_b,
    sx_tick_if.src tk
);

    logic [7:0] cnt_r;
    logic tick_r;
    logic wrap;

    assign wrap = cnt_r >= tk.prescale;
    assign tk.tick = tick_r;

    // ----------------------------------------------------------------
    // Divide by prescale plus one
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_r <= 8'h00;
            tick_r <= 1'b0;
        end
        else
        begin
            cnt_r <= wrap ? 8'h00 : cnt_r + 8'h01; // R21
            tick_r <= wrap;
        end
    end

endmodule : sx_prescaler

/* hdl/sx_serial.sv */
// Serial 8N1 transceiver with an APB register slave.
// Assumes APB master on i_sys_clk; i_rxd is asynchronous to it.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps

module sx_serial
(
    input logic i_sys_clk,
    input logic i_rst_b,
    input logic i_psel,
    input logic i_penable,
    input logic i_pwrite,
    input logic [31:0] i_paddr,
    input logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input logic i_rxd,
    output logic o_txd,
    output logic o_tx_irq,
    output logic o_rx_irq
);

    sx_tick_if tk ();

    logic [15:0] div_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    sx_pkg::sx_tx_state_t tx_state_r;
    logic [9:0] tx_shift_r;
    logic [3:0] tx_bit_r;
    logic [8:0] tx_cnt_r;
    logic [7:0] tx_hold_r;
    logic tx_full_r;
    logic tx_irq_r;
    logic [2:0] rx_s_r;
    logic rx_lvl_r;
    sx_pkg::sx_rx_state_t rx_state_r;
    logic [8:0] rx_cnt_r;
    logic [8:0] rx_lim_r;
    logic [3:0] rx_bit_r;
    logic [7:0] rx_shift_r;
    logic [7:0] rx_hold_r;
    logic rx_full_r;
    logic rx_orun_r;
    logic frame_err_r;
    logic rx_irq_r;

    sx_prescaler u_pre
    (
        .i_sys_clk (i_sys_clk),
        .i_rst_b (i_rst_b),
        .tk (tk.src)
    );

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire [7:0] d1 = div_r[sx_pkg::DIV_D1_LSB +: 8];
    wire [7:0] d2 = div_r[sx_pkg::DIV_D2_LSB +: 8];
    assign tk.prescale = d1;
    wire acc = i_psel & i_penable;
    wire done = acc & pready_r;
    wire sel_st = i_paddr == sx_pkg::ADDR_STATUS;
    wire sel_lo = i_paddr == sx_pkg::ADDR_CHAR_LO;
    wire sel_hi = i_paddr == sx_pkg::ADDR_CHAR_HI;
    wire sel_div = i_paddr == sx_pkg::ADDR_DIV;
    wire hit = sel_st | sel_lo | sel_hi | sel_div;
    wire wr_lo = done & i_pwrite & sel_lo;
    wire wr_hi = done & i_pwrite & sel_hi;
    wire wr_div = done & i_pwrite & sel_div;
    wire wr_chr = wr_lo | wr_hi;
    wire rd_chr = done & ~i_pwrite & (sel_lo | sel_hi);
    // Other bits of the written word are ignored
    wire [7:0] wchar = wr_hi ? i_pwdata[sx_pkg::CHAR_HI_LSB +: sx_pkg::CHAR_W] // R12
                             : i_pwdata[sx_pkg::CHAR_LO_LSB +: sx_pkg::CHAR_W]; // R10

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    wire tx_busy = tx_state_r != sx_pkg::TX_IDLE;
    logic [sx_pkg::ST_W-1:0] status_w;
    assign status_w[sx_pkg::ST_FRAME] = frame_err_r; // R5
    assign status_w[sx_pkg::ST_ORUN] = rx_orun_r; // R5
    assign status_w[sx_pkg::ST_RXFULL] = rx_full_r; // R5
    assign status_w[sx_pkg::ST_TXFULL] = tx_full_r; // R6
    assign status_w[sx_pkg::ST_TXRUN] = tx_busy; // R6
    wire [31:0] rd_mux = sel_st ? {27'h0, status_w}
                       : sel_lo ? {24'h0, rx_hold_r} // R8
                       : sel_hi ? {16'h0, rx_hold_r, 8'h00} // R12
                       : sel_div ? {16'h0, div_r}
                       : 32'h0;

    // One wait state so read data and pready both leave flip-flops
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end
        else
        begin
            pready_r <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~hit;
            prdata_r <= (acc & ~pready_r) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            div_r <= sx_pkg::DIV_RST; // R13
        else if (wr_div)
            div_r <= i_pwdata[15:0]; // R13
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    wire tx_bit_end = tx_busy & tk.tick & sx_pkg::sx_bit_done(tx_cnt_r, {1'b0, d2}); // R15
    wire tx_last = tx_bit_end & (tx_bit_r == sx_pkg::FRAME_BITS - 4'h1); // R4
    wire load_wr = wr_chr & ~tx_busy & ~tx_full_r; // R10
    wire load_hold = tx_full_r & (~tx_busy | tx_last); // R11
    wire tx_load = load_wr | load_hold;
    wire [7:0] tx_src = load_hold ? tx_hold_r : wchar;

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_state_r <= sx_pkg::TX_IDLE;
            tx_shift_r <= '1;
            tx_bit_r <= 4'h0;
            tx_cnt_r <= 9'h000;
        end
        else if (tx_load)
        begin
            tx_state_r <= sx_pkg::TX_SHIFT;
            tx_shift_r <= {sx_pkg::STOP_BIT, tx_src, sx_pkg::START_BIT}; // R1 R3
            tx_bit_r <= 4'h0;
            tx_cnt_r <= 9'h000;
        end
        else if (tx_busy & tk.tick)
        begin
            tx_cnt_r <= tx_bit_end ? 9'h000 : tx_cnt_r + 9'h001;
            if (tx_bit_end)
            begin
                tx_shift_r <= {sx_pkg::LINE_IDLE, tx_shift_r[9:1]}; // R3
                tx_bit_r <= tx_bit_r + 4'h1;
            end
            if (tx_last)
                tx_state_r <= sx_pkg::TX_IDLE; // R4
        end
    end

    // Holding register; a new write beats the drain in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_hold_r <= sx_pkg::CHAR_RST;
            tx_full_r <= 1'b0;
            tx_irq_r <= 1'b0;
        end
        else
        begin
            if (wr_chr & ~load_wr)
            begin
                tx_hold_r <= wchar;
                tx_full_r <= 1'b1; // R11
            end
            else if (load_hold)
                tx_full_r <= 1'b0; // R16
            tx_irq_r <= tx_load; // R16 R22
        end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    // Bit 0 only feeds bit 1; a level counts once bits 1 and 2 agree
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_s_r <= 3'h7;
            rx_lvl_r <= sx_pkg::LINE_IDLE;
        end
        else
        begin
            rx_s_r <= {rx_s_r[1:0], i_rxd};
            if (rx_s_r[1] == rx_s_r[2])
                rx_lvl_r <= rx_s_r[2];
        end
    end

    wire rx_fall = rx_lvl_r & (rx_s_r[2:1] == 2'b00);
    wire rx_samp = tk.tick & sx_pkg::sx_bit_done(rx_cnt_r, rx_lim_r); // R19 R21
    wire rx_done = (rx_state_r == sx_pkg::RX_STOP) & rx_samp;
    // First sample one and a half bits after the start edge
    wire [8:0] rx_first = {1'b0, d2} + {2'b00, d2[7:1]}; // R22

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_state_r <= sx_pkg::RX_IDLE;
            rx_cnt_r <= 9'h000;
            rx_lim_r <= 9'h000;
            rx_bit_r <= 4'h0;
            rx_shift_r <= sx_pkg::CHAR_RST;
        end
        else
        begin
            if (tk.tick)
                rx_cnt_r <= rx_samp ? 9'h000 : rx_cnt_r + 9'h001;
            case (rx_state_r)
                sx_pkg::RX_IDLE:
                begin
                    if (rx_fall)
                    begin
                        rx_state_r <= sx_pkg::RX_DATA; // R18
                        rx_cnt_r <= 9'h000;
                        rx_lim_r <= rx_first; // R22
                        rx_bit_r <= 4'h0;
                    end
                end
                sx_pkg::RX_DATA:
                begin
                    if (rx_samp)
                    begin
                        rx_shift_r <= {rx_lvl_r, rx_shift_r[7:1]}; // R19
                        rx_lim_r <= {1'b0, d2};
                        rx_bit_r <= rx_bit_r + 4'h1;
                        if (rx_bit_r == sx_pkg::DATA_BITS - 4'h1)
                            rx_state_r <= sx_pkg::RX_STOP; // R1
                    end
                end
                sx_pkg::RX_STOP:
                begin
                    if (rx_samp)
                        rx_state_r <= sx_pkg::RX_IDLE; // R20
                end
                default:
                    rx_state_r <= sx_pkg::RX_IDLE;
            endcase
        end
    end

    // A transfer in the cycle of a read leaves the flag set
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_hold_r <= sx_pkg::CHAR_RST;
            rx_full_r <= 1'b0;
            rx_orun_r <= 1'b0;
            frame_err_r <= 1'b0;
            rx_irq_r <= 1'b0;
        end
        else
        begin
            if (rx_done)
            begin
                rx_hold_r <= rx_shift_r;
                rx_orun_r <= rx_full_r; // R7
                frame_err_r <= ~rx_lvl_r; // R20
                rx_full_r <= 1'b1;
            end
            else if (rd_chr)
                rx_full_r <= 1'b0; // R8
            rx_irq_r <= rx_done; // R9 R22
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_prdata = prdata_r;
    assign o_pready = pready_r;
    assign o_pslverr = pslverr_r;
    assign o_txd = tx_shift_r[0];
    assign o_tx_irq = tx_irq_r;
    assign o_rx_irq = rx_irq_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_tx_start;
        tx_load ##1 (o_txd == sx_pkg::START_BIT);
    endsequence

    sequence s_rx_xfer;
        rx_done ##1 rx_full_r;
    endsequence

    property p_idle_high;
        !tx_busy |-> o_txd == sx_pkg::LINE_IDLE;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high"); // R2

    property p_start_bit;
        tx_load |-> s_tx_start;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("no start bit after load"); // R3

    property p_frame_len;
        tx_busy |-> tx_bit_r < sx_pkg::FRAME_BITS;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame over ten bits"); // R4

    property p_tx_irq;
        tx_load |=> o_tx_irq ##1 !o_tx_irq;
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("transmit irq not a pulse on load"); // R16

    // A write in the last bit's cycle is parked one clock, then drained into the idle shifter
    property p_tx_full;
        (wr_chr && tx_busy) |=> tx_full_r && (tx_busy || load_hold);
    endproperty
    a_tx_full: assert property (p_tx_full) else $error("busy write not held"); // R11

    property p_orun;
        rx_done |=> rx_orun_r == $past(rx_full_r);
    endproperty
    a_orun: assert property (p_orun) else $error("overrun not previous full"); // R7

    property p_rx_irq;
        rx_done |-> s_rx_xfer ##0 o_rx_irq;
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("receive irq or full missing"); // R9

    property p_rd_clear;
        (rd_chr && !rx_done) |=> !rx_full_r;
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("read did not clear full"); // R8

    property p_framing;
        rx_done |=> frame_err_r == !$past(rx_lvl_r);
    endproperty
    a_framing: assert property (p_framing) else $error("framing flag wrong"); // R20

endmodule : sx_serial

/* hdl/sx_tick_if.sv */
// Carries the first divider setting to the prescaler and its tick back.
// Assumes both ends sit on the same master clock.
`timescale 1ns/1ps

interface sx_tick_if;
    logic [7:0] prescale;
    logic tick;
    modport src (input prescale, output tick);
    modport dst (output prescale, input tick);
endinterface : sx_tick_if

/* verif/sx_remote_port.sv */
// Behavioural remote serial port: decodes frames on its input, sends frames on demand.
// Assumes 8N1 frames of bit_clks master clocks per bit, set by the bench.
`timescale 1ns/1ps

module sx_remote_port
(
    input wire logic i_sys_clk,
    input wire logic i_line_in,
    output logic o_line_out
);
    int bit_clks = 6;
    int stop_errs = 0;
    logic [7:0] got[$];
    logic [7:0] shift_r;

    initial o_line_out = 1'b1;

    // ----------------------------------------------------------------
    // Receive side
    // ----------------------------------------------------------------
    // Mid-bit sampling tolerates the start bit being one tick off
    always
    begin
        @(negedge i_line_in);
        repeat (bit_clks + bit_clks / 2) @(posedge i_sys_clk);
        for (int i = 0; i < 8; i++)
        begin
            shift_r[i] = i_line_in;
            repeat (bit_clks) @(posedge i_sys_clk);
        end
        if (i_line_in !== 1'b1)
            stop_errs++;
        got.push_back(shift_r);
    end

    // ----------------------------------------------------------------
    // Transmit side
    // ----------------------------------------------------------------
    task automatic send(input logic [7:0] data, input logic stop);
        logic [9:0] frame;
        frame = {stop, data, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge i_sys_clk);
            o_line_out <= frame[i];
            repeat (bit_clks - 1) @(posedge i_sys_clk);
        end
        @(posedge i_sys_clk);
        o_line_out <= 1'b1;
    endtask : send
endmodule : sx_remote_port

/* verif/sx_serial_tb.sv */
// Self-checking bench: APB register sequences plus serial traffic through the remote model.
// Assumes sx_serial answers APB with one wait state.
`timescale 1ns/1ps

module sx_serial_tb;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [31:0] i_paddr = 32'h00000000;
    logic [31:0] i_pwdata = 32'h00000000;
    logic [31:0] o_prdata;
    logic o_pready;
    logic o_pslverr;
    logic line_rx;
    logic o_txd;
    logic o_tx_irq;
    logic o_rx_irq;
    logic last_err;
    logic tx_prev = 1'b0;
    logic rx_prev = 1'b0;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int tx_n = 0;
    int tx_hi = 0;
    int rx_n = 0;
    int rx_hi = 0;

    always #10 i_sys_clk = ~i_sys_clk;

    sx_serial sx_serial_inst (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_rxd(line_rx),
        .o_txd(o_txd), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq));

    sx_remote_port sx_remote_port_inst (.i_sys_clk(i_sys_clk), .i_line_in(o_txd), .o_line_out(line_rx));

    // ----------------------------------------------------------------
    // Monitors and timeout
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk)
    begin
        tx_hi += (o_tx_irq === 1'b1);
        tx_n += (o_tx_irq === 1'b1 && tx_prev !== 1'b1);
        rx_hi += (o_rx_irq === 1'b1);
        rx_n += (o_rx_irq === 1'b1 && rx_prev !== 1'b1);
        tx_prev = o_tx_irq;
        rx_prev = o_rx_irq;
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("checked=%0d failed=%0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until pready is sampled high; the bench timeout ends a hang
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= addr;
        i_pwdata <= wdata;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do
            @(posedge i_sys_clk);
        while (o_pready !== 1'b1);
        rdata = o_prdata;
        last_err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        apb(1'b1, addr, data, unused);
    endtask : wr

    task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        apb(1'b0, addr, 32'h00000000, got);
        chk(got, exp);
    endtask : rd

    task automatic wait_tx(input int n);
        while (sx_remote_port_inst.got.size() < n)
            @(posedge i_sys_clk);
    endtask : wait_tx

    task automatic wait_rx(input int n);
        while (rx_n < n)
            @(posedge i_sys_clk);
    endtask : wait_rx

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        chk({31'h00000000, o_txd}, 32'h00000001);
        rd(sx_pkg::ADDR_STATUS, 32'h00000000);
        rd(sx_pkg::ADDR_DIV, 32'h00000000);
        rd(sx_pkg::ADDR_DIV + 32'h00000004, 32'h00000000);
        chk({31'h00000000, last_err}, 32'h00000001);
        wr(sx_pkg::ADDR_DIV, 32'h00000006);
        rd(sx_pkg::ADDR_DIV, 32'h00000006);
        wr(sx_pkg::ADDR_CHAR_LO, 32'h000001A5);
        rd(sx_pkg::ADDR_STATUS, 32'h00000001);
        chk(tx_n, 32'h00000001);
        wr(sx_pkg::ADDR_CHAR_HI, 32'h00003C00);
        rd(sx_pkg::ADDR_STATUS, 32'h00000003);
        wait_tx(2);
        chk(sx_remote_port_inst.got[0], 32'h000000A5);
        chk(sx_remote_port_inst.got[1], 32'h0000003C);
        sx_remote_port_inst.send(8'h5A, 1'b1);
        wait_rx(1);
        rd(sx_pkg::ADDR_STATUS, 32'h00000004);
        rd(sx_pkg::ADDR_CHAR_LO, 32'h0000005A);
        rd(sx_pkg::ADDR_STATUS, 32'h00000000);
        sx_remote_port_inst.send(8'h81, 1'b1);
        sx_remote_port_inst.send(8'h7E, 1'b1);
        wait_rx(3);
        rd(sx_pkg::ADDR_STATUS, 32'h0000000C);
        rd(sx_pkg::ADDR_CHAR_HI, 32'h00007E00);
        sx_remote_port_inst.send(8'hC3, 1'b0);
        wait_rx(4);
        rd(sx_pkg::ADDR_STATUS, 32'h00000014);
        sx_remote_port_inst.send(8'h0F, 1'b1);
        wait_rx(5);
        rd(sx_pkg::ADDR_STATUS, 32'h0000000C);
        rd(sx_pkg::ADDR_CHAR_LO, 32'h0000000F);
        sx_remote_port_inst.bit_clks = 12;
        wr(sx_pkg::ADDR_DIV, 32'h00000106);
        wr(sx_pkg::ADDR_CHAR_LO, 32'h00000096);
        wait_tx(3);
        chk(sx_remote_port_inst.got[2], 32'h00000096);
        sx_remote_port_inst.send(8'h69, 1'b1);
        wait_rx(6);
        rd(sx_pkg::ADDR_CHAR_LO, 32'h00000069);
        rd(sx_pkg::ADDR_STATUS, 32'h00000000);
        chk(sx_remote_port_inst.stop_errs, 32'h00000000);
        chk(tx_n, 32'h00000003);
        chk(rx_n, 32'h00000006);
        chk(tx_hi, tx_n);
        chk(rx_hi, rx_n);
        wrap_up();
    end
endmodule : sx_serial_tb
